// File: xmk_ext_mem_high_mask_keeper.sv
/*
 * External memory port control: high-address mask, pin release to the
 * general port, bus keeper on the multiplexed lines, and a simple
 * latch/strobe/recover cycle for data-space accesses above internal memory.
 * Assumes a register port on clk, a core that holds its access request
 * until done, and an outside pad ring resolving out/enable pairs.
 */
// Notes on behaviour
// - Keeper holds last write data on released lines; reads replace it with the address byte or a stale settled sample.
// - Keeper off lets released lines float.
// - Keeper ignores interface enable bit.
// - Reserved bits six to three read zero.
// - Mask zero drives full high byte.
// - Driven high bits equal eight minus mask, for masks zero to six.
// - Mask seven releases whole high port.
// - Released pins follow port output, direction.
// - Addresses up to 0x21FF stay internal.
// - Only space above internal reaches external.
// - Interface enable takes pins, overriding direction.
`timescale 1ns/100ps
`include "xmk_cfg.svh"

module xmk_ext_mem_high_mask_keeper (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Interface enable from control register A
  input  wire logic        ext_interface_enable,
  // General port registers of the high-address port
  input  wire logic [7:0]  port_c_out,
  input  wire logic [7:0]  port_c_dir,
  // Core data-space access
  input  wire logic        acc_req,
  input  wire logic        acc_we,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic      [7:0]  acc_rdata,
  output logic             acc_done,
  output logic             acc_internal,
  // Multiplexed address/data lines
  input  wire logic [7:0]  muxed_addr_data_lines_in,
  output logic      [7:0]  muxed_addr_data_lines_out,
  output logic      [7:0]  muxed_addr_data_lines_oe,
  // Bus keeper weak drive
  output logic      [7:0]  keeper_drive,
  output logic      [7:0]  keeper_oe,
  // High-address port pins
  output logic      [7:0]  high_port_out,
  output logic      [7:0]  high_port_oe,
  // Strobes; ALE active high, write and read active low on the pins
  output logic             ale_out,
  output logic             ale_oe,
  output logic             wr_n_out,
  output logic             wr_n_oe,
  output logic             rd_n_out,
  output logic             rd_n_oe
);

  // ==========================================================================
  // Declarations
  xmk_pkg::xmk_byte_t   ctrl_b_reg;
  xmk_pkg::xmk_byte_t   rdata_reg;
  xmk_pkg::xmk_state_t  state_reg;
  xmk_pkg::xmk_state_t  state_next;
  logic [2:0]           cnt_reg;
  logic [2:0]           cnt_next;
  logic [15:0]          addr_reg;
  logic [7:0]           wdata_reg;
  logic                 we_reg;
  logic [2:0]           mask_cur_reg;
  logic [7:0]           last_val_reg;
  logic [7:0]           ad_settled;
  logic [7:0]           hi_sel;
  logic                 bk_en;
  logic [2:0]           mask_live;
  logic                 ctrl_b_hit;
  logic                 is_internal;
  logic                 start_ext;
  logic                 ad_drive;
  logic                 busy_reg;

  // ==========================================================================
  // Pin input synchroniser for the multiplexed lines
  xmk_pin_sync #(
    .W (8)
  ) u_ad_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pin_in  (muxed_addr_data_lines_in),
    .settled (ad_settled)
  );

  // ==========================================================================
  // Register decode
  assign ctrl_b_hit = (reg_addr == `XMK_CTRL_B_ADDR);
  assign bk_en      = ctrl_b_reg[`XMK_BK_BIT];
  assign mask_live  = ctrl_b_reg[`XMK_MASK_MSB:`XMK_MASK_LSB];

  // Control register B; reserved bits never store, so they read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_b_reg <= `XMK_CTRL_B_RESET;
    end else if (reg_wr && ctrl_b_hit) begin
      ctrl_b_reg <= reg_wdata & `XMK_CTRL_B_WMASK;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= `XMK_RD_IDLE;
    end else if (reg_rd && ctrl_b_hit) begin
      rdata_reg <= ctrl_b_reg & `XMK_CTRL_B_WMASK;
    end else begin
      rdata_reg <= `XMK_RD_IDLE;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================================
  // Access classification
  // Internal region answers locally; no external cycle is started.
  // Busy is set one cycle after done, so done itself blocks a restart
  // by the request that is still held in that cycle.
  assign is_internal = (acc_addr <= `XMK_INT_LIMIT);
  assign start_ext   = acc_req && !busy_reg && !is_internal
                       && ext_interface_enable && !acc_done
                       && (state_reg == xmk_pkg::XMK_IDLE);

  // ==========================================================================
  // Cycle state machine, next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      xmk_pkg::XMK_IDLE: begin
        if (start_ext) begin
          state_next = xmk_pkg::XMK_LATCH;
          cnt_next   = `XMK_LATCH_CYC;
        end
      end
      xmk_pkg::XMK_LATCH: begin
        if (cnt_reg == 3'h1) begin
          state_next = xmk_pkg::XMK_STROBE;
          cnt_next   = `XMK_STROBE_CYC;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      xmk_pkg::XMK_STROBE: begin
        if (cnt_reg == 3'h1) begin
          state_next = xmk_pkg::XMK_RECOVER;
          cnt_next   = `XMK_RECOVER_CYC;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      xmk_pkg::XMK_RECOVER: begin
        if (cnt_reg == 3'h1) begin
          state_next = xmk_pkg::XMK_IDLE;
          cnt_next   = 3'h0;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default: begin
        state_next = xmk_pkg::XMK_IDLE;
        cnt_next   = 3'h0;
      end
    endcase
  end

  // State and counter flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= xmk_pkg::XMK_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ==========================================================================
  // Access capture; the mask is sampled at the start of each cycle, so a
  // register write takes hold on the very next access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg     <= 16'h0000;
      wdata_reg    <= 8'h00;
      we_reg       <= 1'b0;
      mask_cur_reg <= 3'h0;
    end else if (start_ext) begin
      addr_reg     <= acc_addr;
      wdata_reg    <= acc_wdata;
      we_reg       <= acc_we;
      mask_cur_reg <= mask_live;
    end else if (state_reg == xmk_pkg::XMK_IDLE) begin
      mask_cur_reg <= mask_live;
    end
  end

  // Busy flag blocks a held request from restarting after done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else if (acc_done || acc_internal) begin
      busy_reg <= 1'b1;
    end else if (!acc_req) begin
      busy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Completion and read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_done     <= 1'b0;
      acc_internal <= 1'b0;
      acc_rdata    <= 8'h00;
    end else begin
      acc_done     <= 1'b0;
      acc_internal <= 1'b0;
      if (acc_req && !busy_reg && is_internal && !acc_done
          && !acc_internal) begin
        acc_internal <= 1'b1;
      end else if (acc_req && !busy_reg && !is_internal
                   && !ext_interface_enable && !acc_done) begin
        acc_done  <= 1'b1;
        acc_rdata <= 8'h00;
      end else if ((state_reg == xmk_pkg::XMK_RECOVER)
                   && (cnt_reg == 3'h1)) begin
        acc_done <= 1'b1;
        if (!we_reg) begin
          acc_rdata <= ad_settled;
        end
      end
    end
  end

  // ==========================================================================
  // High-address mask decode: bit i drives address when below 8 - mask; mask 7 drives none
  always_comb begin
    if (mask_cur_reg == `XMK_MASK_ALL) begin
      hi_sel = 8'h00;
    end else begin
      hi_sel = 8'hFF >> mask_cur_reg;
    end
    if (!ext_interface_enable) begin
      hi_sel = 8'h00;
    end
  end

  // Released pins revert to the general port registers
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (hi_sel[i]) begin
        high_port_out[i] = addr_reg[8+i];
        high_port_oe[i]  = 1'b1;
      end else begin
        high_port_out[i] = port_c_out[i];
        high_port_oe[i]  = port_c_dir[i];
      end
    end
  end

  // ==========================================================================
  // Multiplexed lines: address low byte at latch, write data at strobe
  assign ad_drive = ext_interface_enable
                    && ((state_reg == xmk_pkg::XMK_LATCH)
                        || ((state_reg == xmk_pkg::XMK_STROBE) && we_reg));

  always_comb begin
    if (state_reg == xmk_pkg::XMK_LATCH) begin
      muxed_addr_data_lines_out = addr_reg[7:0];
    end else begin
      muxed_addr_data_lines_out = wdata_reg;
    end
    muxed_addr_data_lines_oe = {8{ad_drive}};
  end

  // ==========================================================================
  // Strobes; owned by the interface while it is enabled
  assign ale_out  = (state_reg == xmk_pkg::XMK_LATCH);
  assign wr_n_out = !((state_reg == xmk_pkg::XMK_STROBE) && we_reg);
  assign rd_n_out = !((state_reg == xmk_pkg::XMK_STROBE) && !we_reg);
  assign ale_oe   = ext_interface_enable;
  assign wr_n_oe  = ext_interface_enable;
  assign rd_n_oe  = ext_interface_enable;

  // ==========================================================================
  // Bus keeper: remember what the port drove, or the settled sample when off or in the strobe.
  // The settled sample lags the pins by four cycles, as long as the strobe, so with the
  // keeper on, read data driven by the memory arrives too late to be kept.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_val_reg <= 8'h00;
    end else if (ad_drive) begin
      last_val_reg <= muxed_addr_data_lines_out;
    end else if (!bk_en) begin
      last_val_reg <= ad_settled;
    end else if (state_reg == xmk_pkg::XMK_STROBE) begin
      last_val_reg <= ad_settled;
    end
  end

  // Weak drive only while the lines are released; not gated by the
  // interface enable, and off entirely when the keeper bit is clear
  assign keeper_drive = last_val_reg;
  assign keeper_oe    = {8{bk_en && !ad_drive}};

endmodule

// File: xmk_cfg.svh
/*
 * Constants of the high-mask and bus-keeper block: register offset, field
 * positions, reset value, address limits and cycle counts.
 * Assumes inclusion by bare name from the top design module only.
 */
`ifndef XMK_CFG_SVH
`define XMK_CFG_SVH

// ==========================================================================
// Register map
`define XMK_CTRL_B_ADDR   8'h75
`define XMK_CTRL_B_RESET  8'h00
`define XMK_CTRL_B_WMASK  8'h87
`define XMK_BK_BIT        7
`define XMK_MASK_MSB      2
`define XMK_MASK_LSB      0
`define XMK_MASK_ALL      3'h7
`define XMK_RD_IDLE       8'h00

// ==========================================================================
// Address space
`define XMK_INT_LIMIT     16'h21FF

// ==========================================================================
// External cycle timing, in clock cycles
`define XMK_LATCH_CYC     3'h1
`define XMK_STROBE_CYC    3'h4
`define XMK_RECOVER_CYC   3'h1

`endif

// File: xmk_pkg.sv
/*
 * Types of the high-mask and bus-keeper block.
 * Assumes nothing beyond the constants header.
 */
package xmk_pkg;

  // ========================================================================
  // External cycle states, one-hot
  typedef enum logic [3:0] {
    XMK_IDLE    = 4'h1,
    XMK_LATCH   = 4'h2,
    XMK_STROBE  = 4'h4,
    XMK_RECOVER = 4'h8
  } xmk_state_t;

  typedef logic [7:0] xmk_byte_t;

endpackage

// File: xmk_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter, one per bit.
 * Assumes the inputs are asynchronous pins and clk is the system clock.
 */
`timescale 1ns/100ps

module xmk_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Pin side and settled output
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] settled
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;

  // ========================================================================
  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settled <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          settled[i] <= stage2_reg[i];
        end
      end
    end
  end

endmodule

// File: xmk_mem_model.sv
/*
 * Behavioural external memory on the multiplexed port.
 * Assumes resolved pad levels from the bench and 16-bit latched addresses.
 */
`timescale 1ns/100ps

module xmk_mem_model (
  // Strobes and pads
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] ad,
  // Read drive back onto the pads
  output logic      [7:0] drive,
  output logic            oe
);
  // ========================================================================
  // Storage
  logic [7:0]  mem [0:65535];
  logic [15:0] lat_addr;

  // Latch address, then take data while the write strobe is low
  always @(posedge clk) begin
    if (ale) begin
      lat_addr <= {hi, ad};
    end
    if (!wr_n) begin
      mem[lat_addr] <= ad;
    end
  end

  // Drives only while read strobe is low, so it never fights the port
  assign oe    = !rd_n;
  assign drive = oe ? mem[lat_addr] : 8'h00;
endmodule

// File: xmk_high_mask_monitor.sv
/*
 * Checker of the high-mask and bus-keeper block.
 * Assumes binding to the top module; sees its ports only.
 */
`timescale 1ns/100ps

module xmk_high_mask_monitor (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Port registers and core access
  input wire logic        ext_interface_enable,
  input wire logic [7:0]  port_c_out,
  input wire logic [7:0]  port_c_dir,
  input wire logic        acc_req,
  input wire logic        acc_we,
  input wire logic [15:0] acc_addr,
  input wire logic        acc_done,
  input wire logic        acc_internal,
  // Pins
  input wire logic [7:0]  muxed_addr_data_lines_oe,
  input wire logic [7:0]  keeper_oe,
  input wire logic [7:0]  high_port_out,
  input wire logic [7:0]  high_port_oe,
  input wire logic        ale_out,
  input wire logic        ale_oe,
  input wire logic        wr_n_out,
  input wire logic        wr_n_oe,
  input wire logic        rd_n_out,
  input wire logic        rd_n_oe
);
  // ========================================================================
  // Shadow of the control register, rebuilt from writes
  logic [7:0] ctl_reg;
  logic [7:0] drv;
  logic       ext_take;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h75) begin
      ctl_reg <= reg_wdata & 8'h87;
    end
  end

  // Driven high bits; all three mask bits set drives none
  assign drv = (ctl_reg[2:0] == 3'h7) ? 8'h00 : (8'hFF >> ctl_reg[2:0]);
  assign ext_take = acc_addr > 16'h21FF && ext_interface_enable;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ========================================================================
  // Assertions
  keeper_on_a: assert property (
    ctl_reg[7] && muxed_addr_data_lines_oe == 8'h00 |-> keeper_oe == 8'hFF)
    else $error("keeper idle on released lines");
  keeper_off_a: assert property (
    !ctl_reg[7] |-> keeper_oe == 8'h00) else $error("keeper drives while off");
  reserved_zero_a: assert property (
    reg_rdata[6:3] == 4'h0) else $error("reserved bits read nonzero");
  read_value_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h75 |-> reg_rdata == $past(ctl_reg))
    else $error("control read value wrong");
  read_idle_a: assert property (
    !($past(reg_rd) && $past(reg_addr) == 8'h75) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  high_oe_a: assert property (
    ext_interface_enable && ale_out |-> high_port_oe == (drv | port_c_dir))
    else $error("high port enables wrong");
  high_pins_a: assert property (
    ext_interface_enable && ale_out |-> high_port_out ==
      ((acc_addr[15:8] & drv) | (port_c_out & ~drv)))
    else $error("high port values wrong");
  iface_off_a: assert property (
    !ext_interface_enable |-> high_port_oe == port_c_dir &&
      muxed_addr_data_lines_oe == 8'h00 && !ale_oe && !wr_n_oe && !rd_n_oe)
    else $error("pins taken while disabled");
  iface_on_a: assert property (
    ext_interface_enable |-> ale_oe && wr_n_oe && rd_n_oe)
    else $error("strobes not taken while enabled");
  internal_a: assert property (
    $rose(acc_req) && acc_addr <= 16'h21FF |=> acc_internal && !ale_out)
    else $error("internal address left the chip");
  ext_cycle_a: assert property (
    $rose(acc_req) && ext_take |=> ale_out && !acc_done ##1
      (!ale_out && !acc_done)[*5] ##1 acc_done)
    else $error("external cycle shape wrong");
  write_strobe_a: assert property (
    $rose(acc_req) && ext_take && acc_we |-> ##2
      (!wr_n_out && rd_n_out)[*4] ##1 wr_n_out)
    else $error("write strobe wrong");

  // Main scenarios reached
  cover property (ale_out && ctl_reg[2:0] == 3'h7);
  cover property ($rose(keeper_oe[0]));
  cover property (acc_internal);
endmodule

// File: tb_top.sv
/*
 * Self-checking bench of the high-mask and bus-keeper block.
 * Assumes the design, memory model and checker are compiled before it.
 */
`timescale 1ns/100ps

module tb_top;
  // ========================================================================
  // Stimulus and observed signals
  logic        clk, nrst, reg_wr, reg_rd, ext_interface_enable;
  logic        acc_req, acc_we, ale_seen, int_seen;
  logic [7:0]  reg_addr, reg_wdata, port_c_out, port_c_dir, acc_wdata;
  logic [7:0]  hi_oe_seen, hi_out_seen, pad_seen, d, drv;
  logic [15:0] acc_addr;
  logic [7:0]  reg_rdata, acc_rdata, ad_out, ad_oe, kp_drive, kp_oe;
  logic [7:0]  hp_out, hp_oe, ad_pad, hi_pad, mem_drive;
  logic        acc_done, acc_internal, ale_out, wr_n_out, rd_n_out, mem_oe;
  logic        ale_oe, wr_n_oe, rd_n_oe;
  int          num_errors, compares, cyc;

  // Pads: released lines show a pattern that moves every cycle
  assign ad_pad = ad_oe[0] ? ad_out : mem_oe ? mem_drive :
                  kp_oe[0] ? kp_drive : ~cyc[7:0];
  assign hi_pad = (hp_out & hp_oe) | (~hp_oe & cyc[7:0]);

  xmk_ext_mem_high_mask_keeper i_xmk_ext_mem_high_mask_keeper (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_interface_enable(ext_interface_enable), .port_c_out(port_c_out),
    .port_c_dir(port_c_dir), .acc_req(acc_req), .acc_we(acc_we),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_done(acc_done), .acc_internal(acc_internal),
    .muxed_addr_data_lines_in(ad_pad), .muxed_addr_data_lines_out(ad_out),
    .muxed_addr_data_lines_oe(ad_oe), .keeper_drive(kp_drive),
    .keeper_oe(kp_oe), .high_port_out(hp_out), .high_port_oe(hp_oe),
    .ale_out(ale_out), .ale_oe(ale_oe), .wr_n_out(wr_n_out),
    .wr_n_oe(wr_n_oe), .rd_n_out(rd_n_out), .rd_n_oe(rd_n_oe));

  xmk_mem_model i_xmk_mem_model (
    .clk(clk), .ale(ale_out & ale_oe), .wr_n(wr_n_out | !wr_n_oe),
    .rd_n(rd_n_out | !rd_n_oe), .hi(hi_pad), .ad(ad_pad),
    .drive(mem_drive), .oe(mem_oe));

  // ========================================================================
  // Clock and hang guard
  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      results();
    end
  end

  // ========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Values read at the edge are those of the cycle just ended
  task automatic access(input logic [15:0] a, input logic we,
                        input logic [7:0] v);
    logic fin;
    fin = 1'b0;
    @(posedge clk);
    acc_req   <= 1'b1;
    acc_we    <= we;
    acc_addr  <= a;
    acc_wdata <= v;
    ale_seen = 1'b0;
    int_seen = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ale_out) begin
        ale_seen    = 1'b1;
        hi_oe_seen  = hp_oe;
        hi_out_seen = hp_out;
      end
      int_seen = acc_internal;
      pad_seen = ad_pad;
      if (acc_done || acc_internal) begin
        fin = 1'b1;
        break;
      end
    end
    acc_req <= 1'b0;
    // An access that never answers counts as a mismatch
    if (!fin) begin
      num_errors++;
    end
  endtask

  task automatic results;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_regs;
    rd_reg(8'h75);
    chk(d, 8'h00);
    wr_reg(8'h75, 8'hFF);
    rd_reg(8'h75);
    chk(d, 8'h87);
    wr_reg(8'h74, 8'h00);
    rd_reg(8'h74);
    chk(d, 8'h00);
    $display("test registers done");
  endtask

  // Mask applied to the very next access after each write
  task automatic t_masks;
    ext_interface_enable <= 1'b1;
    port_c_dir <= 8'h0F;
    port_c_out <= 8'h5A;
    for (int m = 0; m < 8; m++) begin
      wr_reg(8'h75, 8'(m));
      access(16'hC300, 1'b1, 8'(m));
      drv = (m == 7) ? 8'h00 : (8'hFF >> m);
      chk(hi_oe_seen, drv | 8'h0F);
      chk(hi_out_seen, (8'hC3 & drv) | (8'h5A & ~drv));
    end
    $display("test masks done");
  endtask

  task automatic t_mem;
    port_c_dir <= 8'hFF;
    port_c_out <= 8'h00;
    wr_reg(8'h75, 8'h00);
    access(16'h4001, 1'b1, 8'hAA);
    access(16'h4001, 1'b0, 8'h00);
    chk(acc_rdata, 8'hAA);
    wr_reg(8'h75, 8'h02);
    access(16'h4001, 1'b1, 8'h55);
    chk(i_xmk_mem_model.mem[16'h0001], 8'h55);
    // Top line released and held low, as a 32 KB part sees it
    wr_reg(8'h75, 8'h01);
    access(16'hA1FF, 1'b1, 8'h96);
    chk(i_xmk_mem_model.mem[16'h21FF], 8'h96);
    wr_reg(8'h75, 8'h02);
    access(16'h21FF, 1'b0, 8'h00);
    chk({int_seen, ale_seen}, 2'b10);
    access(16'h2200, 1'b0, 8'h00);
    chk({int_seen, ale_seen}, 2'b01);
    $display("test memory done");
  endtask

  task automatic t_keeper;
    wr_reg(8'h75, 8'h80);
    access(16'h4002, 1'b1, 8'h3C);
    chk(pad_seen, 8'h3C);
    ext_interface_enable <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk(kp_oe, 8'hFF);
    port_c_dir <= 8'hA5;
    port_c_out <= 8'h3C;
    access(16'h4000, 1'b0, 8'h00);
    chk({ale_seen, acc_rdata}, 9'h000);
    chk(hp_oe, 8'hA5);
    wr_reg(8'h75, 8'h00);
    @(posedge clk);
    chk(kp_oe, 8'h00);
    $display("test keeper done");
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {reg_wr, reg_rd, ext_interface_enable, acc_req, acc_we} = 5'h00;
    {reg_addr, reg_wdata, port_c_out, port_c_dir, acc_wdata} = 40'h0;
    acc_addr = 16'h0000;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_masks();
    t_mem();
    t_keeper();
    results();
  end
endmodule

bind xmk_ext_mem_high_mask_keeper xmk_high_mask_monitor
  i_xmk_high_mask_monitor (.*);
